// ---- tb/tcc_cpu_model.sv ----
`timescale 1ns/10ps
// ----------------------------------------------------------------
// CPU vector logic stand-in
// ----------------------------------------------------------------
module tcc_cpu_model (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [3:0] irq,
  input  wire logic       ack_en,
  input  wire logic [3:0] lat,
  output logic      [3:0] ack
);
  logic [3:0] cnt_reg;

  // Lowest pending vector wins; lat adds wait cycles to mimic a busy core
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 4'h0;
      ack     <= 4'h0;
    end else begin
      ack <= 4'h0;
      // No second pulse while the flag is still falling
      if (ack_en && (|irq) && (ack == 4'h0)) begin
        if (cnt_reg >= lat) begin
          ack     <= irq & (~irq + 4'h1);
          cnt_reg <= 4'h0;
        end else begin
          cnt_reg <= cnt_reg + 4'h1;
        end
      end else begin
        cnt_reg <= 4'h0;
      end
    end
  end
endmodule : tcc_cpu_model

// ---- tb/tcc_timer16_irq_test.sv ----
`timescale 1ns/10ps
module tcc_timer16_irq_test;
  import tcc_pkg::*;
  logic CLK = 0, RSTN = 0, AVS_READ = 0, AVS_WRITE = 0, TIMER_TICK = 0;
  logic CAPTURE_PIN = 1, GLOBAL_IRQ_EN = 0, ack_en = 0;
  logic COUNTER_AT_TOP = 0, ANALOG_CMP_OUT = 1;
  wire logic [3:0]  WAVEFORM_MODE_SEL;
  wire logic [1:0]  match;
  int n_match [2] = '{0, 0};
  logic [7:0]  AVS_ADDRESS = 8'h00;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [15:0] COUNTER_VALUE = 16'h0, v;
  logic [3:0]  lat = 4'h0;
  logic [7:0]  b;
  wire logic [31:0] AVS_READDATA;
  wire logic        AVS_WAITREQUEST, CAPTURE_IS_TOP;
  wire logic [15:0] COMPARE_A_VALUE, COMPARE_B_VALUE, CAPTURE_VALUE;
  wire logic [3:0]  irq, ack;
  int n_errors = 0, checks = 0;

  always #20 CLK = ~CLK;

  tcc_timer16_irq uut (.CLK, .RSTN, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
    .AVS_BYTEENABLE(4'hF), .AVS_READDATA, .AVS_WAITREQUEST, .COUNTER_VALUE, .TIMER_TICK,
    .COUNTER_AT_TOP, .CAPTURE_PIN, .ANALOG_CMP_OUT, .GLOBAL_IRQ_EN,
    .ACK_CAPTURE(ack[0]), .ACK_CMP_A(ack[1]), .ACK_CMP_B(ack[2]), .ACK_OVERFLOW(ack[3]),
    .COMPARE_A_VALUE, .COMPARE_B_VALUE, .CAPTURE_VALUE, .WAVEFORM_MODE_SEL,
    .CAPTURE_IS_TOP, .CMP_A_MATCH(match[0]), .CMP_B_MATCH(match[1]), .IRQ_CAPTURE(irq[0]),
    .IRQ_CMP_A(irq[1]), .IRQ_CMP_B(irq[2]), .IRQ_OVERFLOW(irq[3]));

  tcc_cpu_model cpu (.clk(CLK), .rstn(RSTN), .irq(irq), .ack_en(ack_en), .lat(lat), .ack(ack));

  // Waveform match pulses counted per channel; each stands one cycle
  always @(posedge CLK) begin
    if (match[0]) n_match[0]++;
    if (match[1]) n_match[1]++;
  end

  // ----------------------------------------------------------------
  // Bus cycles and compares
  // ----------------------------------------------------------------
  // Request is held until waitrequest is seen low at a rising edge
  task automatic bus(input logic rd, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= {24'h0, d};
    AVS_READ <= rd;
    AVS_WRITE <= !rd;
    // Only the watchdog ends a wait that never finishes
    do begin
      @(posedge CLK);
    end while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA[7:0];
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b0, a, d, q);
  endtask : wr

  task automatic rchk(input string s, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b1, a, 8'h00, q);
    checks++;
    if (q !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", s, e, q);
    end
  endtask : rchk

  task automatic chk_pin(input string s, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask : chk_pin

  // One timer clock with the given count
  task automatic tick(input logic [15:0] c);
    @(posedge CLK);
    COUNTER_VALUE <= c;
    TIMER_TICK <= 1'b1;
    @(posedge CLK);
    TIMER_TICK <= 1'b0;
  endtask : tick

  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge CLK);
    RSTN <= 1'b1;
    rchk("mask_rst", OFS_MASK, MASK_RST);
    wr(OFS_MASK, 8'hFF);
    rchk("mask_rw", OFS_MASK, 8'hFF);
    rchk("unmapped", 8'h3C, 8'h00);
    // Channel A prompt ack, channel B slow ack
    for (int i = 0; i < 2; i++) begin
      v = i ? 16'h5A3C : 16'hA5C3;
      b = 8'h1 << (BIT_CMPA - i);
      wr(i ? OFS_CMPB_HI : OFS_CMPA_HI, v[15:8]);
      wr(i ? OFS_CMPB_LO : OFS_CMPA_LO, v[7:0]);
      @(negedge CLK);
      chk_pin("cmp_val", v, i ? COMPARE_B_VALUE : COMPARE_A_VALUE);
      wr(OFS_FORCE, 8'h1 << i);
      rchk("flag_force", OFS_FLAGS, 8'h00);
      chk_pin("match_force", 16'h1, 16'(n_match[i]));
      tick(v);
      tick(v + 16'h1);
      rchk("flag_match", OFS_FLAGS, b);
      chk_pin("match_cnt", 16'h2, 16'(n_match[i]));
      wr(OFS_MASK, b);
      @(negedge CLK);
      chk_pin("irq_gie_off", 16'h0, {15'h0, irq[1+i]});
      @(posedge CLK);
      GLOBAL_IRQ_EN <= 1'b1;
      @(negedge CLK);
      chk_pin("irq_on", 16'h1, {15'h0, irq[1+i]});
      @(posedge CLK);
      lat <= i ? 4'h3 : 4'h0;
      ack_en <= 1'b1;
      repeat (8) @(posedge CLK);
      rchk("flag_ack", OFS_FLAGS, 8'h00);
      ack_en <= 1'b0;
      GLOBAL_IRQ_EN <= 1'b0;
    end
    tick(COUNT_MAX);
    rchk("ovf_set", OFS_FLAGS, 8'h1 << BIT_OVF);
    wr(OFS_FLAGS, 8'h1 << BIT_OVF);
    rchk("ovf_clr", OFS_FLAGS, 8'h00);
    // Held count makes the snapshot exact despite sync latency
    COUNTER_VALUE <= 16'h1234;
    CAPTURE_PIN <= 1'b0;
    repeat (12) @(posedge CLK);
    chk_pin("capt", 16'h1234, CAPTURE_VALUE);
    rchk("capt_flag", OFS_FLAGS, 8'h20);
    wr(OFS_FLAGS, 8'h00);
    rchk("capt_keep", OFS_FLAGS, 8'h20);
    wr(OFS_FLAGS, 8'h20);
    rchk("capt_clr", OFS_FLAGS, 8'h00);
    COUNTER_VALUE <= 16'h5678;
    CAPTURE_PIN <= 1'b1;
    repeat (12) @(posedge CLK);
    chk_pin("capt_rise", 16'h1234, CAPTURE_VALUE);
    rchk("capt_lo", OFS_CAPT_LO, 8'h34);
    rchk("capt_hi", OFS_CAPT_HI, 8'h12);
    // Rising-edge select through the filter: the fall is ignored
    wr(OFS_CTRL, 8'h30);
    CAPTURE_PIN <= 1'b0;
    repeat (16) @(posedge CLK);
    chk_pin("capt_fall_ign", 16'h1234, CAPTURE_VALUE);
    COUNTER_VALUE <= 16'h9ABC;
    CAPTURE_PIN <= 1'b1;
    repeat (16) @(posedge CLK);
    chk_pin("capt_filt", 16'h9ABC, CAPTURE_VALUE);
    // Comparator source, falling edge, no filter
    wr(OFS_CTRL, 8'h40);
    COUNTER_VALUE <= 16'h0F0F;
    ANALOG_CMP_OUT <= 1'b0;
    repeat (12) @(posedge CLK);
    chk_pin("capt_ana", 16'h0F0F, CAPTURE_VALUE);
    wr(OFS_CTRL, 8'h0C);
    @(negedge CLK);
    chk_pin("capt_top", 16'h1, {15'h0, CAPTURE_IS_TOP});
    chk_pin("mode_sel", 16'h000C, {12'h0, WAVEFORM_MODE_SEL});
    @(posedge CLK);
    CAPTURE_PIN <= 1'b0;
    repeat (12) @(posedge CLK);
    chk_pin("capt_off", 16'h0F0F, CAPTURE_VALUE);
    // Top reached while capture is top sets the capture flag
    wr(OFS_FLAGS, 8'h20);
    COUNTER_AT_TOP <= 1'b1;
    tick(16'h0F0F);
    COUNTER_AT_TOP <= 1'b0;
    rchk("capt_top_flag", OFS_FLAGS, 8'h20);
    close_out();
  end

  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    repeat (4000) @(posedge CLK);
    n_errors++;
    close_out();
  end
endmodule : tcc_timer16_irq_test

// ---- verilog/tcc_capture_cond.sv ----
`timescale 1ns/10ps
module tcc_capture_cond #(
  parameter int FILT_LEN = tcc_pkg::FILTER_LEN
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic src_raw,
  input  wire logic filter_en,
  input  wire logic edge_sel,
  input  wire logic enable,
  output logic      event_pulse
);
  import tcc_pkg::*;

  initial begin
    if (FILT_LEN < 2 || FILT_LEN > 16) $error("FILT_LEN out of range");
  end

  logic [SYNC_STAGES-1:0] sync_reg;
  logic                   stable_reg;
  logic                   filt_reg;
  logic                   filt_prev_reg;
  logic [3:0]             run_reg;
  logic                   level;

  // Three-stage synchroniser; first stage feeds only the second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) sync_reg <= '1;
    else       sync_reg <= {sync_reg[SYNC_STAGES-2:0], src_raw};
  end

  // A change counts once stages two and three agree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) stable_reg <= 1'b1;
    else if (sync_reg[1] == sync_reg[2]) stable_reg <= sync_reg[2];
  end

  // Noise filter: output follows after FILT_LEN equal samples
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_reg  <= 4'h0;
      filt_reg <= 1'b1;
    end else if (stable_reg == filt_reg) begin
      run_reg <= 4'h0;
    end else if (run_reg == 4'(FILT_LEN - 1)) begin
      run_reg  <= 4'h0;
      filt_reg <= stable_reg;
    end else begin
      run_reg <= run_reg + 4'h1;
    end
  end

  assign level = filter_en ? filt_reg : stable_reg;

  // Edge detect; disabled input gives no events at all
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      filt_prev_reg <= 1'b1;
      event_pulse   <= 1'b0;
    end else begin
      filt_prev_reg <= level;
      event_pulse   <= enable && (level != filt_prev_reg) && (level == edge_sel);
    end
  end

endmodule : tcc_capture_cond

// ---- verilog/tcc_cmp_chan.sv ----
`timescale 1ns/10ps
module tcc_cmp_chan (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        tick,
  input  wire logic [15:0] counter,
  input  wire logic [15:0] value,
  input  wire logic        force_strobe,
  output logic             wave_match,
  output logic             flag_set
);
  import tcc_pkg::*;

  logic pend_reg;

  // Equality noted on one timer cycle, flag raised on the next
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) pend_reg <= 1'b0;
    else if (tick) pend_reg <= (counter == value);
  end

  assign flag_set = tick && pend_reg;

  // Forced strobe reaches the waveform only, never the flag
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) wave_match <= 1'b0;
    else wave_match <= (tick && (counter == value)) || force_strobe;
  end

endmodule : tcc_cmp_chan

// ---- verilog/tcc_pkg.sv ----
package tcc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CMPA_LO = 8'h00;
  localparam logic [7:0] OFS_CMPA_HI = 8'h04;
  localparam logic [7:0] OFS_CMPB_LO = 8'h08;
  localparam logic [7:0] OFS_CMPB_HI = 8'h0C;
  localparam logic [7:0] OFS_CAPT_LO = 8'h10;
  localparam logic [7:0] OFS_CAPT_HI = 8'h14;
  localparam logic [7:0] OFS_MASK    = 8'h18;
  localparam logic [7:0] OFS_FLAGS   = 8'h1C;
  localparam logic [7:0] OFS_CTRL    = 8'h20;
  localparam logic [7:0] OFS_FORCE   = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_CAPT     = 5;
  localparam int BIT_CMPA     = 4;
  localparam int BIT_CMPB     = 3;
  localparam int BIT_OVF      = 2;
  localparam int CTRL_EDGE    = 4;
  localparam int CTRL_FILTER  = 5;
  localparam int CTRL_ANASRC  = 6;
  localparam int FORCE_A      = 0;
  localparam int FORCE_B      = 1;
  localparam logic [7:0] FLAGS_OWNED = 8'h3C;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0]  MASK_RST    = 8'h00;
  localparam logic [7:0]  FLAGS_RST   = 8'h00;
  localparam logic [7:0]  CTRL_RST    = 8'h00;
  localparam logic [15:0] VALUE_RST   = 16'h0000;
  localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
  localparam logic [15:0] COUNT_BOT   = 16'h0000;
  localparam int          FILTER_LEN  = 4;
  localparam int          SYNC_STAGES = 3;

  typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_RESP = 2'b10} tcc_bus_t;
  typedef enum logic [2:0] {OVF_MAX = 3'b001, OVF_BOT = 3'b010, OVF_TOP = 3'b100} tcc_ovf_t;

  // Where the overflow flag is raised for each waveform mode
  function automatic tcc_ovf_t tcc_ovf_point(input logic [3:0] mode);
    unique case (mode)
      4'h0, 4'h4, 4'hC, 4'hD:       return OVF_MAX;
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: return OVF_TOP;
      default:                      return OVF_BOT;
    endcase
  endfunction : tcc_ovf_point

  // Modes that use the capture register as top
  function automatic logic tcc_capt_is_top(input logic [3:0] mode);
    return (mode == 4'h8) || (mode == 4'hA) || (mode == 4'hC) || (mode == 4'hE);
  endfunction : tcc_capt_is_top

endpackage : tcc_pkg

// ---- verilog/tcc_timer16_irq.sv ----
// Added by the designer: register access over Avalon-MM and the register addresses.
`timescale 1ns/10ps
module tcc_timer16_irq (
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic [15:0] COUNTER_VALUE,
  input  wire logic        TIMER_TICK,
  input  wire logic        COUNTER_AT_TOP,
  input  wire logic        CAPTURE_PIN,
  input  wire logic        ANALOG_CMP_OUT,
  input  wire logic        GLOBAL_IRQ_EN,
  input  wire logic        ACK_CAPTURE,
  input  wire logic        ACK_CMP_A,
  input  wire logic        ACK_CMP_B,
  input  wire logic        ACK_OVERFLOW,
  output logic      [15:0] COMPARE_A_VALUE,
  output logic      [15:0] COMPARE_B_VALUE,
  output logic      [15:0] CAPTURE_VALUE,
  output logic      [3:0]  WAVEFORM_MODE_SEL,
  output logic             CAPTURE_IS_TOP,
  output logic             CMP_A_MATCH,
  output logic             CMP_B_MATCH,
  output logic             IRQ_CAPTURE,
  output logic             IRQ_CMP_A,
  output logic             IRQ_CMP_B,
  output logic             IRQ_OVERFLOW
);
  import tcc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  tcc_bus_t    bus_reg;
  tcc_bus_t    bus_next;
  logic        req;
  logic        acc;
  logic        wr_acc;
  logic        rd_acc;
  logic [7:0]  rd_mux;
  logic [31:0] rdata_reg;
  logic [7:0]  capt_snap_reg;
  logic [7:0]  temp_reg;
  logic [15:0] cmp_reg [2];
  logic [15:0] capt_reg;
  logic [7:0]  mask_reg;
  logic [7:0]  flags_reg;
  logic [7:0]  flags_next;
  logic [7:0]  flag_set;
  logic [7:0]  flag_clr;
  logic [7:0]  ctrl_reg;
  logic [1:0]  force_reg;
  logic [1:0]  cmp_set;
  logic [1:0]  wave_match;
  logic [7:0]  irq_vec;
  logic        capt_top;
  logic        capt_evt;
  logic        capt_src;
  logic        ovf_hit;
  tcc_ovf_t    ovf_pt;

  // ----------------------------------------------------------------
  // Avalon slave: one wait cycle, then the access is taken
  // ----------------------------------------------------------------
  assign req    = AVS_READ || AVS_WRITE;
  assign acc    = req && (bus_reg == BUS_RESP);
  assign wr_acc = acc && AVS_WRITE && AVS_BYTEENABLE[0];
  assign rd_acc = acc && AVS_READ;
  assign AVS_WAITREQUEST = req && (bus_reg == BUS_IDLE);
  assign AVS_READDATA    = rdata_reg;

  // Handshake state
  always_comb begin
    bus_next = bus_reg;
    unique case (bus_reg)
      BUS_IDLE: if (req) bus_next = BUS_RESP;
      BUS_RESP: bus_next = BUS_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) bus_reg <= BUS_IDLE;
    else       bus_reg <= bus_next;
  end

  // Read multiplexer; unmapped words read as zero
  always_comb begin
    unique case (AVS_ADDRESS)
      OFS_CMPA_LO: rd_mux = cmp_reg[0][7:0];
      OFS_CMPA_HI: rd_mux = cmp_reg[0][15:8];
      OFS_CMPB_LO: rd_mux = cmp_reg[1][7:0];
      OFS_CMPB_HI: rd_mux = cmp_reg[1][15:8];
      OFS_CAPT_LO: rd_mux = capt_reg[7:0];
      OFS_CAPT_HI: rd_mux = temp_reg;
      OFS_MASK:    rd_mux = mask_reg;
      OFS_FLAGS:   rd_mux = flags_reg;
      OFS_CTRL:    rd_mux = ctrl_reg;
      default:     rd_mux = 8'h00;
    endcase
  end

  // Read data and the matching high byte sampled in the same cycle,
  // so a capture landing during the access cannot tear the pair
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_reg     <= 32'h0000_0000;
      capt_snap_reg <= 8'h00;
    end else if (AVS_READ && bus_reg == BUS_IDLE) begin
      rdata_reg     <= {24'h00_0000, rd_mux};
      capt_snap_reg <= capt_reg[15:8];
    end
  end

  // ----------------------------------------------------------------
  // Shared high-byte latch and 16-bit registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      temp_reg <= 8'h00;
    end else if (wr_acc && (AVS_ADDRESS == OFS_CMPA_HI || AVS_ADDRESS == OFS_CMPB_HI ||
                            AVS_ADDRESS == OFS_CAPT_HI)) begin
      temp_reg <= AVS_WRITEDATA[7:0];
    end else if (rd_acc && AVS_ADDRESS == OFS_CAPT_LO) begin
      temp_reg <= capt_snap_reg;
    end
  end

  // Compare values: low-byte write commits both bytes at once
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cmp_reg[0] <= VALUE_RST;
      cmp_reg[1] <= VALUE_RST;
    end else if (wr_acc && AVS_ADDRESS == OFS_CMPA_LO) begin
      cmp_reg[0] <= {temp_reg, AVS_WRITEDATA[7:0]};
    end else if (wr_acc && AVS_ADDRESS == OFS_CMPB_LO) begin
      cmp_reg[1] <= {temp_reg, AVS_WRITEDATA[7:0]};
    end
  end

  // Capture register; a software write outranks a same-cycle capture
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      capt_reg <= VALUE_RST;
    end else if (wr_acc && AVS_ADDRESS == OFS_CAPT_LO) begin
      capt_reg <= {temp_reg, AVS_WRITEDATA[7:0]};
    end else if (capt_evt) begin
      capt_reg <= COUNTER_VALUE;
    end
  end

  // ----------------------------------------------------------------
  // Mask, control and force strobes
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) mask_reg <= MASK_RST;
    else if (wr_acc && AVS_ADDRESS == OFS_MASK) mask_reg <= AVS_WRITEDATA[7:0];
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) ctrl_reg <= CTRL_RST;
    else if (wr_acc && AVS_ADDRESS == OFS_CTRL) ctrl_reg <= AVS_WRITEDATA[7:0];
  end

  // Force bits are one-cycle strobes and read back as zero
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) force_reg <= 2'b00;
    else if (wr_acc && AVS_ADDRESS == OFS_FORCE)
      force_reg <= {AVS_WRITEDATA[FORCE_B], AVS_WRITEDATA[FORCE_A]};
    else force_reg <= 2'b00;
  end

  assign WAVEFORM_MODE_SEL = ctrl_reg[3:0];
  assign capt_top          = tcc_capt_is_top(ctrl_reg[3:0]);
  assign CAPTURE_IS_TOP    = capt_top;
  assign ovf_pt            = tcc_ovf_point(ctrl_reg[3:0]);
  assign COMPARE_A_VALUE   = cmp_reg[0];
  assign COMPARE_B_VALUE   = cmp_reg[1];
  assign CAPTURE_VALUE     = capt_reg;

  // ----------------------------------------------------------------
  // Capture input and compare channels
  // ----------------------------------------------------------------
  // Source chosen ahead of the synchroniser: one crossing, not two
  assign capt_src = ctrl_reg[CTRL_ANASRC] ? ANALOG_CMP_OUT : CAPTURE_PIN;

  tcc_capture_cond #(.FILT_LEN(FILTER_LEN)) u_capt (
    .clk         (CLK),
    .rstn        (RSTN),
    .src_raw     (capt_src),
    .filter_en   (ctrl_reg[CTRL_FILTER]),
    .edge_sel    (ctrl_reg[CTRL_EDGE]),
    .enable      (!capt_top),
    .event_pulse (capt_evt)
  );

  for (genvar ch = 0; ch < 2; ch++) begin : g_cmp
    tcc_cmp_chan u_chan (
      .clk          (CLK),
      .rstn         (RSTN),
      .tick         (TIMER_TICK),
      .counter      (COUNTER_VALUE),
      .value        (cmp_reg[ch]),
      .force_strobe (force_reg[ch]),
      .wave_match   (wave_match[ch]),
      .flag_set     (cmp_set[ch])
    );
  end

  assign CMP_A_MATCH = wave_match[0];
  assign CMP_B_MATCH = wave_match[1];

  // ----------------------------------------------------------------
  // Flags: set by events, cleared by acknowledge or write-one
  // ----------------------------------------------------------------
  // Overflow point follows the waveform mode
  always_comb begin
    unique case (ovf_pt)
      OVF_MAX: ovf_hit = TIMER_TICK && COUNTER_VALUE == COUNT_MAX;
      OVF_BOT: ovf_hit = TIMER_TICK && COUNTER_VALUE == COUNT_BOT;
      OVF_TOP: ovf_hit = TIMER_TICK && COUNTER_AT_TOP;
      default: ovf_hit = 1'b0;
    endcase
  end

  always_comb begin
    flag_set = 8'h00;
    flag_set[BIT_CAPT] = capt_top ? (TIMER_TICK && COUNTER_AT_TOP) : capt_evt;
    flag_set[BIT_CMPA] = cmp_set[0];
    flag_set[BIT_CMPB] = cmp_set[1];
    flag_set[BIT_OVF]  = ovf_hit;
  end

  always_comb begin
    flag_clr = (wr_acc && AVS_ADDRESS == OFS_FLAGS) ? AVS_WRITEDATA[7:0] : 8'h00;
    flag_clr[BIT_CAPT] = flag_clr[BIT_CAPT] || ACK_CAPTURE;
    flag_clr[BIT_CMPA] = flag_clr[BIT_CMPA] || ACK_CMP_A;
    flag_clr[BIT_CMPB] = flag_clr[BIT_CMPB] || ACK_CMP_B;
    flag_clr[BIT_OVF]  = flag_clr[BIT_OVF] || ACK_OVERFLOW;
  end

  // Set is applied after clear so a coincident event survives
  assign flags_next = ((flags_reg & ~flag_clr) | flag_set) & FLAGS_OWNED;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) flags_reg <= FLAGS_RST;
    else       flags_reg <= flags_next;
  end

  // ----------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------
  assign irq_vec      = flags_reg & mask_reg & {8{GLOBAL_IRQ_EN}};
  assign IRQ_CAPTURE  = irq_vec[BIT_CAPT];
  assign IRQ_CMP_A    = irq_vec[BIT_CMPA];
  assign IRQ_CMP_B    = irq_vec[BIT_CMPB];
  assign IRQ_OVERFLOW = irq_vec[BIT_OVF];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  // Checker helper: equality with A seen on the latest timer tick,
  // so the flag check needs no unbounded wait for the next tick
  logic chk_eq_a_reg;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) chk_eq_a_reg <= 1'b0;
    else if (TIMER_TICK) chk_eq_a_reg <= (COUNTER_VALUE == cmp_reg[0]);
  end

  irq_capture_a: assert property ($rose(flags_reg[BIT_CAPT]) && mask_reg[BIT_CAPT] &&
                                  GLOBAL_IRQ_EN |-> IRQ_CAPTURE)
    else $error("capture irq missing");
  irq_cmp_a_a: assert property (IRQ_CMP_A |-> mask_reg[BIT_CMPA] && GLOBAL_IRQ_EN)
    else $error("compare A irq without enable");
  irq_cmp_b_a: assert property (!GLOBAL_IRQ_EN |-> !IRQ_CMP_B)
    else $error("compare B irq while globally disabled");
  irq_ovf_a: assert property (IRQ_OVERFLOW |-> flags_reg[BIT_OVF])
    else $error("overflow irq without flag");
  cmp_a_flag_a: assert property (TIMER_TICK && chk_eq_a_reg |=> flags_reg[BIT_CMPA])
    else $error("compare A flag late");
  force_flag_a: assert property ($rose(flags_reg[BIT_CMPB]) |-> $past(TIMER_TICK))
    else $error("compare B flag rose without timer tick");
  set_wins_a: assert property (ACK_CMP_A && cmp_set[0] |=> flags_reg[BIT_CMPA])
    else $error("clear beat set");
  ack_clear_a: assert property (ACK_CAPTURE && !flag_set[BIT_CAPT] |=>
                                !flags_reg[BIT_CAPT])
    else $error("capture flag not cleared by acknowledge");
  capt_copy_a: assert property (capt_evt && !wr_acc |=>
                                capt_reg == $past(COUNTER_VALUE))
    else $error("capture value not copied");
  capt_top_a: assert property (capt_top ##3 capt_top |-> !capt_evt)
    else $error("capture while register is top");
  ovf_max_a: assert property (TIMER_TICK && ctrl_reg[3:0] == 4'h0 &&
                              COUNTER_VALUE == COUNT_MAX |=> flags_reg[BIT_OVF])
    else $error("overflow flag missed at max");
  mask_hold_a: assert property (!(wr_acc && AVS_ADDRESS == OFS_MASK) |=>
                                $stable(mask_reg))
    else $error("mask changed without write");
  wait_bound_a: assert property (req |-> ##[0:1] !AVS_WAITREQUEST)
    else $error("bus wait too long");

  capture_c: cover property (capt_evt ##1 flags_reg[BIT_CAPT]);
  cmp_a_c:   cover property ($rose(flags_reg[BIT_CMPA]) ##[1:4] IRQ_CMP_A);
  cmp16_c:   cover property (wr_acc && AVS_ADDRESS == OFS_CMPB_HI ##[1:8]
                             wr_acc && AVS_ADDRESS == OFS_CMPB_LO);
  ovf_c:     cover property (IRQ_OVERFLOW ##1 ACK_OVERFLOW);

endmodule : tcc_timer16_irq
